// ---- hdl/ctpg_defs.vh ----
// Function
// [RULE1] reference bars start AA, 33, F0, 7F
// [RULE2] then 55, CC, 0F and last 80
// [RULE3] last bar stretches to fill the line
// [RULE4] bar count is one, two, four or eight
// [RULE5] line and bar lengths counted in bytes
// [RULE6] header datatype and virtual channel programmable
// [RULE7] active lines and total lines programmable
// [RULE8] line period counted in 10 ns units
// [RULE9] front porch blank lines precede frame end
// [RULE10] back porch blank lines follow frame start
// [RULE11] software keeps bars whole datatype blocks
// [RULE12] runs on transmit clock, feeds transmitter directly
// [RULE13] fixed mode fills image with pattern block
// [RULE14] fixed mode bars alternate block and inverse
// [RULE15] block length one to sixteen, repeated
// [RULE16] sixteen byte registers hold the block
// [RULE17] pattern block written through indirect page 0
// [RULE18] software writes page, index, then data
// [RULE19] block ascending; line restarts byte and bar
`ifndef CTPG_DEFS_VH
`define CTPG_DEFS_VH

// reference bar bytes, in bar order
`define CTPG_BAR0 8'hAA
`define CTPG_BAR1 8'h33
`define CTPG_BAR2 8'hF0
`define CTPG_BAR3 8'h7F
`define CTPG_BAR4 8'h55
`define CTPG_BAR5 8'hCC
`define CTPG_BAR6 8'h0F
`define CTPG_BAR7 8'h80

// bar count select codes and last bar index
`define CTPG_BARS_1    2'h0
`define CTPG_BARS_2    2'h1
`define CTPG_BARS_4    2'h2
`define CTPG_LAST_1    3'h0
`define CTPG_LAST_2    3'h1
`define CTPG_LAST_4    3'h3
`define CTPG_LAST_8    3'h7

// line timing: period unit and clock period in ns
`define CTPG_UNIT_NS   24'h00000A
`define CTPG_CLK_NS    24'h000008

// short packet datatypes for frame start and end
`define CTPG_DT_FS     6'h00
`define CTPG_DT_FE     6'h01
`define CTPG_WC_SHORT  16'h0000

// indirect access: page and index window of the block
`define CTPG_PAGE_PAT  8'h00
`define CTPG_IDX_HI    4'h1
`define CTPG_BLK_MAX   5'h10

// reset value of the pattern block bytes
`define CTPG_PAT_RST   8'h00

`endif

// ---- hdl/ctpg_pat_store.v ----
`timescale 1ns/1ns
`include "ctpg_defs.vh"

module ctpg_pat_store
(
    input  wire       i_sys_clk,
    input  wire       i_rst_n,
    input  wire       i_wr,
    input  wire [3:0] i_wr_addr,
    input  wire [7:0] i_wr_data,
    input  wire [3:0] i_rd_addr,
    input  wire       i_invert,
    input  wire       i_ref_sel,
    input  wire [7:0] i_ref_byte,
    output wire [7:0] o_byte
);

    reg  [127:0] store_reg;
    reg  [7:0]   byte_reg;
    wire [7:0]   rd_byte;

    // one byte register per block position
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_ent
            always @(posedge i_sys_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                    store_reg[g*8 +: 8] <= `CTPG_PAT_RST;
                else if (i_wr && (i_wr_addr == g))
                    store_reg[g*8 +: 8] <= i_wr_data; // [RULE16]
            end
        end
    endgenerate

    assign rd_byte = store_reg[i_rd_addr*8 +: 8];

    // output byte register, shared by both pattern modes
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            byte_reg <= 8'h00;
        else if (i_ref_sel)
            byte_reg <= i_ref_byte;
        else
            byte_reg <= rd_byte ^ {8{i_invert}}; // [RULE14]
    end

    assign o_byte = byte_reg;

endmodule // ctpg_pat_store

// ---- hdl/ctpg_top.v ----
`timescale 1ns/1ns
`include "ctpg_defs.vh"

module ctpg_top
#(
    parameter CNT_W   = 16,
    parameter PORCH_W = 8
)
(
    input  wire               i_sys_clk,
    input  wire               i_rst_n,
    input  wire               i_pg_enable,
    input  wire               i_fixed_mode,
    input  wire [1:0]         i_bar_cnt_sel,
    input  wire [CNT_W-1:0]   i_line_size,
    input  wire [CNT_W-1:0]   i_bar_size,
    input  wire [5:0]         i_data_type,
    input  wire [1:0]         i_virt_chan,
    input  wire [CNT_W-1:0]   i_act_lines,
    input  wire [CNT_W-1:0]   i_tot_lines,
    input  wire [CNT_W-1:0]   i_line_period,
    input  wire [PORCH_W-1:0] i_vbp,
    input  wire [PORCH_W-1:0] i_vfp,
    input  wire [4:0]         i_blk_len,
    input  wire               i_ind_wr,
    input  wire [7:0]         i_ind_page,
    input  wire [7:0]         i_ind_index,
    input  wire [7:0]         i_ind_data,
    output wire               o_pkt_start,
    output wire               o_pkt_long,
    output wire [7:0]         o_pkt_di,
    output wire [15:0]        o_pkt_wc,
    output wire [7:0]         o_data,
    output wire               o_data_valid,
    output wire               o_pkt_end,
    output wire               o_busy
);

    // sequencer states; off keeps the line timer cleared
    localparam S_OFF  = 2'b00;
    localparam S_IDLE = 2'b01;
    localparam S_DATA = 2'b10;

    // sequencer, line timer and output flops
    reg  [1:0]       state_reg;
    reg              pend_reg;
    reg  [23:0]      acc_ns_reg;
    reg  [CNT_W-1:0] lcnt_reg;
    reg  [CNT_W-1:0] byte_cnt_reg;
    reg  [CNT_W-1:0] bar_pos_reg;
    reg  [2:0]       bar_idx_reg;
    reg  [3:0]       blk_idx_reg;
    reg              start_reg;
    reg              long_reg;
    reg  [7:0]       di_reg;
    reg  [15:0]      wc_reg;
    reg              valid_reg;
    reg              end_reg;
    reg  [2:0]       last_bar;
    reg  [7:0]       ref_byte;

    // line timing and packet role decodes
    wire [23:0]      period_ns;
    wire [23:0]      acc_ns_next;
    wire             line_tick;
    wire [CNT_W:0]   lcnt_inc;
    wire [CNT_W+1:0] act_end;
    wire [CNT_W+1:0] fe_line;
    wire [CNT_W+1:0] lcnt_ext;
    wire             is_fs;
    wire             is_fe;
    wire             is_act;
    wire [3:0]       blk_last;
    wire             last_byte;
    wire             bar_done;
    wire             pat_wr;

    // line period in ns; 10 ns units do not divide the 8 ns clock,
    // so an ns accumulator, cleared at each line start, rounds the line up to whole clocks
    assign period_ns   = i_line_period * `CTPG_UNIT_NS; // [RULE8]
    assign acc_ns_next = acc_ns_reg + `CTPG_CLK_NS;
    assign line_tick   = (state_reg != S_OFF) &&
                         (acc_ns_next >= period_ns); // [RULE8]
    assign lcnt_inc    = {1'b0, lcnt_reg} + {{CNT_W{1'b0}}, 1'b1};

    // line roles within the frame, line 0 carries frame start
    assign lcnt_ext = {2'b00, lcnt_reg};
    assign act_end  = {{(CNT_W+2-PORCH_W){1'b0}}, i_vbp} +
                      {2'b00, i_act_lines};
    assign fe_line  = act_end + {{(CNT_W+2-PORCH_W){1'b0}}, i_vfp} +
                      {{(CNT_W+1){1'b0}}, 1'b1}; // [RULE9]
    assign is_fs    = (lcnt_reg == {CNT_W{1'b0}});
    assign is_act   = (lcnt_ext > {{(CNT_W+2-PORCH_W){1'b0}}, i_vbp}) &&
                      (lcnt_ext <= act_end); // [RULE10] [RULE7]
    assign is_fe    = (lcnt_ext == fe_line); // [RULE9]

    // block length of zero is taken as one, above sixteen as sixteen
    assign blk_last = (i_blk_len == 5'h00) ? 4'h0 :
                      (i_blk_len >= `CTPG_BLK_MAX) ? 4'hF :
                      (i_blk_len[3:0] - 4'h1); // [RULE15]

    assign last_byte = (byte_cnt_reg == (i_line_size - 1'b1)); // [RULE5]
    assign bar_done  = (bar_pos_reg == (i_bar_size - 1'b1)) &&
                       (bar_idx_reg != last_bar); // [RULE3]

    // indirect writes land in the block only on the pattern page
    assign pat_wr = i_ind_wr && (i_ind_page == `CTPG_PAGE_PAT) &&
                    (i_ind_index[7:4] == `CTPG_IDX_HI); // [RULE17]

    // last bar index from the bar count select
    always @*
    begin
        case (i_bar_cnt_sel) // [RULE4]
            `CTPG_BARS_1: last_bar = `CTPG_LAST_1;
            `CTPG_BARS_2: last_bar = `CTPG_LAST_2;
            `CTPG_BARS_4: last_bar = `CTPG_LAST_4;
            default:      last_bar = `CTPG_LAST_8;
        endcase
    end

    // reference colour of the current bar
    always @*
    begin
        case (bar_idx_reg)
            3'h0:    ref_byte = `CTPG_BAR0; // [RULE1]
            3'h1:    ref_byte = `CTPG_BAR1; // [RULE1]
            3'h2:    ref_byte = `CTPG_BAR2; // [RULE1]
            3'h3:    ref_byte = `CTPG_BAR3; // [RULE1]
            3'h4:    ref_byte = `CTPG_BAR4; // [RULE2]
            3'h5:    ref_byte = `CTPG_BAR5; // [RULE2]
            3'h6:    ref_byte = `CTPG_BAR6; // [RULE2]
            default: ref_byte = `CTPG_BAR7; // [RULE2]
        endcase
    end

    // line timer and line counter, free of the packet state except off
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_ns_reg <= 24'h000000;
            lcnt_reg   <= {CNT_W{1'b0}};
        end
        else if (state_reg == S_OFF)
        begin
            acc_ns_reg <= 24'h000000;
            lcnt_reg   <= {CNT_W{1'b0}};
        end
        else if (line_tick)
        begin
            acc_ns_reg <= 24'h000000;
            // wrap once the last blanking line has run
            if (lcnt_inc >= {1'b0, i_tot_lines}) // [RULE7]
                lcnt_reg <= {CNT_W{1'b0}};
            else
                lcnt_reg <= lcnt_inc[CNT_W-1:0];
        end
        else
        begin
            acc_ns_reg <= acc_ns_next;
        end
    end

    // packet sequencer; a line start that falls while a payload is
    // still running waits in pend_reg, so a short period delays
    // the next header instead of cutting the packet
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg    <= S_OFF;
            pend_reg     <= 1'b0;
            byte_cnt_reg <= {CNT_W{1'b0}};
            bar_pos_reg  <= {CNT_W{1'b0}};
            bar_idx_reg  <= 3'h0;
            blk_idx_reg  <= 4'h0;
            start_reg    <= 1'b0;
            long_reg     <= 1'b0;
            di_reg       <= 8'h00;
            wc_reg       <= 16'h0000;
            valid_reg    <= 1'b0;
            end_reg      <= 1'b0;
        end
        else
        begin
            start_reg <= 1'b0;
            valid_reg <= 1'b0;
            end_reg   <= 1'b0;
            case (state_reg)
                S_OFF:
                begin
                    // di and wc keep their last value while off
                    long_reg <= 1'b0;
                    if (i_pg_enable)
                    begin
                        state_reg <= S_IDLE;
                        pend_reg  <= 1'b1;
                    end
                end
                S_IDLE:
                begin
                    // a start not taken in this cycle is dropped
                    pend_reg <= line_tick;
                    // every line restarts byte, bar and block
                    byte_cnt_reg <= {CNT_W{1'b0}}; // [RULE19]
                    bar_pos_reg  <= {CNT_W{1'b0}}; // [RULE19]
                    bar_idx_reg  <= 3'h0; // [RULE19]
                    blk_idx_reg  <= 4'h0; // [RULE19]
                    // disable wins over a pending line start
                    if (!i_pg_enable)
                        state_reg <= S_OFF;
                    // frame start and frame end are short packets
                    else if (pend_reg && is_fs)
                    begin
                        start_reg <= 1'b1;
                        end_reg   <= 1'b1;
                        long_reg  <= 1'b0;
                        di_reg    <= {i_virt_chan, `CTPG_DT_FS}; // [RULE6]
                        wc_reg    <= `CTPG_WC_SHORT;
                    end
                    else if (pend_reg && is_fe)
                    begin
                        start_reg <= 1'b1;
                        end_reg   <= 1'b1;
                        long_reg  <= 1'b0;
                        di_reg    <= {i_virt_chan, `CTPG_DT_FE}; // [RULE6]
                        wc_reg    <= `CTPG_WC_SHORT;
                    end
                    // long packet; an empty line ends on its header
                    else if (pend_reg && is_act)
                    begin
                        start_reg <= 1'b1;
                        long_reg  <= 1'b1;
                        di_reg    <= {i_virt_chan, i_data_type}; // [RULE6]
                        wc_reg    <= i_line_size[15:0]; // [RULE5]
                        if (i_line_size == {CNT_W{1'b0}})
                            end_reg <= 1'b1;
                        else
                            state_reg <= S_DATA;
                    end
                end
                S_DATA:
                begin
                    // one byte per clock, end pulse with the last
                    pend_reg     <= pend_reg | line_tick;
                    valid_reg    <= 1'b1;
                    end_reg      <= last_byte;
                    byte_cnt_reg <= byte_cnt_reg + 1'b1;
                    // block bytes in ascending order, wrapping
                    if (blk_idx_reg == blk_last)
                        blk_idx_reg <= 4'h0; // [RULE15]
                    else
                        blk_idx_reg <= blk_idx_reg + 4'h1; // [RULE19]
                    // last bar holds until the line is full
                    if (bar_done)
                    begin
                        bar_pos_reg <= {CNT_W{1'b0}};
                        bar_idx_reg <= bar_idx_reg + 3'h1;
                    end
                    else if (bar_idx_reg != last_bar)
                        bar_pos_reg <= bar_pos_reg + 1'b1; // [RULE3]
                    // disable cuts the line with no end pulse; the
                    // transmitter has to drop a packet left open
                    if (!i_pg_enable)
                        state_reg <= S_OFF;
                    else if (last_byte)
                        state_reg <= S_IDLE;
                end
                default:
                begin
                    // an unused code falls back to off
                    state_reg <= S_OFF;
                end
            endcase
        end
    end

    // byte source: reference colour or block byte, inverted on odd
    // bars; its output flop lines up with valid_reg
    ctpg_pat_store u_store
    (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_wr       (pat_wr),
        .i_wr_addr  (i_ind_index[3:0]),
        .i_wr_data  (i_ind_data),
        .i_rd_addr  (blk_idx_reg), // [RULE13]
        .i_invert   (bar_idx_reg[0]), // [RULE14]
        .i_ref_sel  (!i_fixed_mode),
        .i_ref_byte (ref_byte),
        .o_byte     (o_data)
    );

    // outputs go straight to the transmitter, no crossing
    assign o_pkt_start  = start_reg; // [RULE12]
    assign o_pkt_long   = long_reg;
    assign o_pkt_di     = di_reg;
    assign o_pkt_wc     = wc_reg;
    assign o_data_valid = valid_reg;
    assign o_pkt_end    = end_reg;
    // busy decodes the state flop alone, no input reaches it
    assign o_busy       = (state_reg != S_OFF);

endmodule // ctpg_top

// ---- verif/ctpg_top_asserts.sv ----
`timescale 1ns/1ns
module ctpg_top_chk
#(
    parameter CNT_W   = 16,
    parameter PORCH_W = 8
)
(
    input wire             i_sys_clk,
    input wire             i_rst_n,
    input wire             i_pg_enable,
    input wire             i_fixed_mode,
    input wire [CNT_W-1:0] i_line_size,
    input wire [5:0]       i_data_type,
    input wire [1:0]       i_virt_chan,
    input wire             o_pkt_start,
    input wire             o_pkt_long,
    input wire [7:0]       o_pkt_di,
    input wire [15:0]      o_pkt_wc,
    input wire [7:0]       o_data,
    input wire             o_data_valid,
    input wire             o_pkt_end,
    input wire             o_busy
);
    reg [15:0] cnt_reg;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // bytes seen since the last header
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_reg <= 16'h0000;
        else if (o_pkt_start)
            cnt_reg <= 16'h0000;
        else if (o_data_valid)
            cnt_reg <= cnt_reg + 16'h0001;
    end
    a_enable_frame_start: assert property (
        $rose(i_pg_enable) && !o_busy |->
        ##2 (o_pkt_start && !o_pkt_long && o_pkt_di[5:0] == 6'h00))
        else $error("frame start late");
    a_header_then_data: assert property (
        o_pkt_start && o_pkt_long && o_pkt_wc != 16'h0000 |=>
        o_data_valid && !o_pkt_start)
        else $error("payload not after header");
    a_valid_no_start: assert property (
        o_data_valid |-> !o_pkt_start)
        else $error("byte with header");
    a_short_end: assert property (
        o_pkt_start && !o_pkt_long |-> o_pkt_end && o_pkt_wc == 16'h0000)
        else $error("short packet form");
    a_short_vc: assert property (
        o_pkt_start && !o_pkt_long |->
        o_pkt_di[7:6] == i_virt_chan && o_pkt_di[5:1] == 5'h00)
        else $error("short header id");
    a_long_header: assert property (
        o_pkt_start && o_pkt_long |->
        o_pkt_di == {i_virt_chan, i_data_type} && o_pkt_wc == i_line_size)
        else $error("long header");
    a_first_bar: assert property (
        o_pkt_start && o_pkt_long && !i_fixed_mode &&
        o_pkt_wc != 16'h0000 |=> o_data == 8'hAA)
        else $error("first bar byte");
    a_len_count: assert property (
        o_pkt_end && o_data_valid |-> cnt_reg + 16'h0001 == o_pkt_wc)
        else $error("line length");
    a_end_data: assert property (
        o_pkt_end && o_pkt_long && o_pkt_wc != 16'h0000 |-> o_data_valid)
        else $error("end without byte");
endmodule // ctpg_top_chk

bind ctpg_top ctpg_top_chk #(.CNT_W(CNT_W), .PORCH_W(PORCH_W)) u_chk
    (.i_sys_clk, .i_rst_n, .i_pg_enable, .i_fixed_mode, .i_line_size,
     .i_data_type, .i_virt_chan, .o_pkt_start, .o_pkt_long, .o_pkt_di,
     .o_pkt_wc, .o_data, .o_data_valid, .o_pkt_end, .o_busy);

// ---- verif/ctpg_tx_model.sv ----
`timescale 1ns/1ns
module ctpg_tx_model
(
    input wire        i_sys_clk,
    input wire        i_rst_n,
    input wire        i_clear,
    input wire        i_pkt_start,
    input wire        i_pkt_long,
    input wire [7:0]  i_pkt_di,
    input wire [15:0] i_pkt_wc,
    input wire [7:0]  i_data,
    input wire        i_data_valid
);
    integer      cyc_reg;
    integer      cnt_reg;
    integer      pos_reg;
    integer      t_reg  [0:7];
    logic [7:0]  di_reg [0:7];
    logic        lg_reg [0:7];
    logic [15:0] wc_reg [0:7];
    logic [7:0]  b_reg  [0:7][0:15];
    // takes the first eight headers and sixteen bytes of each as they come; it cannot stall
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cyc_reg <= 0;
            cnt_reg <= 0;
            pos_reg <= 0;
        end
        else
        begin
            cyc_reg <= cyc_reg + 1;
            if (i_clear)
                cnt_reg <= 0;
            else if (i_pkt_start && cnt_reg < 8)
            begin
                t_reg[cnt_reg]  <= cyc_reg;
                di_reg[cnt_reg] <= i_pkt_di;
                lg_reg[cnt_reg] <= i_pkt_long;
                wc_reg[cnt_reg] <= i_pkt_wc;
                cnt_reg         <= cnt_reg + 1;
                pos_reg         <= 0;
            end
            else if (i_data_valid && cnt_reg > 0 && pos_reg < 16)
            begin
                b_reg[cnt_reg-1][pos_reg] <= i_data;
                pos_reg                   <= pos_reg + 1;
            end
        end
    end
endmodule // ctpg_tx_model

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_pg_enable = 1'b0;
    logic        i_fixed_mode = 1'b0, i_ind_wr = 1'b0, clr = 1'b0;
    logic [1:0]  i_bar_cnt_sel = 2'h3, i_virt_chan = 2'h2;
    logic [15:0] i_line_size = 16'h0009, i_bar_size = 16'h0001;
    logic [15:0] i_act_lines = 16'h0002, i_tot_lines = 16'h0006;
    logic [15:0] i_line_period = 16'h0008;
    logic [7:0]  i_vbp = 8'h01, i_vfp = 8'h01;
    logic [7:0]  i_ind_page = 8'h00, i_ind_index = 8'h00, i_ind_data = 8'h00;
    logic [5:0]  i_data_type = 6'h2A; // one byte blocks suit any bar size
    logic [4:0]  i_blk_len = 5'h03;
    logic        o_pkt_start, o_pkt_long, o_data_valid, o_pkt_end, o_busy;
    logic [7:0]  o_pkt_di, o_data;
    logic [15:0] o_pkt_wc;
    logic [7:0]  ex [0:8];
    integer      err_total = 0;
    integer      check_count = 0;
    always #4 i_sys_clk = ~i_sys_clk;
    ctpg_top uut (.i_sys_clk, .i_rst_n, .i_pg_enable, .i_fixed_mode,
        .i_bar_cnt_sel, .i_line_size, .i_bar_size, .i_data_type,
        .i_virt_chan, .i_act_lines, .i_tot_lines, .i_line_period, .i_vbp,
        .i_vfp, .i_blk_len, .i_ind_wr, .i_ind_page, .i_ind_index,
        .i_ind_data, .o_pkt_start, .o_pkt_long, .o_pkt_di, .o_pkt_wc,
        .o_data, .o_data_valid, .o_pkt_end, .o_busy);
    ctpg_tx_model model (.i_sys_clk, .i_rst_n, .i_clear(clr),
        .i_pkt_start(o_pkt_start), .i_pkt_long(o_pkt_long),
        .i_pkt_di(o_pkt_di), .i_pkt_wc(o_pkt_wc), .i_data(o_data),
        .i_data_valid(o_data_valid));
    task chk(input string nm, input logic [15:0] seen,
             input logic [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // page, then index, then data, all in one strobe
    task ind_wr(input logic [7:0] pg, input logic [7:0] ix,
                input logic [7:0] d);
        @(negedge i_sys_clk);
        i_ind_page  = pg;
        i_ind_index = ix;
        i_ind_data  = d;
        i_ind_wr    = 1'b1;
        @(negedge i_sys_clk);
        i_ind_wr    = 1'b0;
    endtask
    // one frame: fs, two lines, fe; the bound guards a stuck generator
    task run_frame;
        integer n;
        @(negedge i_sys_clk);
        clr = 1'b1;
        @(negedge i_sys_clk);
        clr = 1'b0;
        i_pg_enable = 1'b1;
        n = 0;
        while (model.cnt_reg < 4 && n < 400)
        begin
            @(negedge i_sys_clk);
            n = n + 1;
        end
        // stop well before the next frame start falls due
        repeat (4) @(negedge i_sys_clk);
        chk("busy on", o_busy, 16'h0001);
        i_pg_enable = 1'b0;
        repeat (3) @(negedge i_sys_clk);
        chk("busy off", o_busy, 16'h0000);
        chk("packets", model.cnt_reg, 16'h0004);
    endtask
    task chk_line(input integer p);
        integer k;
        for (k = 0; k < i_line_size; k = k + 1)
            chk("byte", model.b_reg[p][k], ex[k]);
    endtask
    // eight bars, last one stretched by a byte; frame timing at 10 cycles
    task t_ref;
        ex = '{8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F,
               8'h80, 8'h80};
        run_frame;
        chk("fs di", model.di_reg[0], 16'h0080);
        chk("long di", model.di_reg[1], 16'h00AA);
        chk("wc", model.wc_reg[1], 16'h0009);
        chk("fe di", model.di_reg[3], 16'h0081);
        chk("vbp gap", model.t_reg[1] - model.t_reg[0], 16'h0014);
        chk("period", model.t_reg[2] - model.t_reg[1], 16'h000A);
        chk("vfp gap", model.t_reg[3] - model.t_reg[2], 16'h0014);
        chk("long", model.lg_reg[2], 16'h0001);
        chk_line(1);
        chk_line(2);
    endtask
    // one, two and four bars of two bytes on a six byte line
    task t_bars;
        integer s;
        i_line_size = 16'h0006;
        i_bar_size  = 16'h0002;
        for (s = 0; s < 3; s = s + 1)
        begin
            i_bar_cnt_sel = s[1:0];
            ex = '{8'hAA, 8'hAA, 8'h33, 8'h33, 8'h33, 8'h33,
                   8'h00, 8'h00, 8'h00};
            if (s == 0)
                ex = '{8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA, 8'hAA,
                       8'h00, 8'h00, 8'h00};
            if (s == 2)
            begin
                ex[4] = 8'hF0;
                ex[5] = 8'hF0;
            end
            run_frame;
            chk_line(1);
        end
    endtask
    // three byte block, second bar inverted; stray writes are ignored
    task t_fixed;
        ind_wr(8'h00, 8'h10, 8'h11);
        ind_wr(8'h00, 8'h11, 8'h22);
        ind_wr(8'h00, 8'h12, 8'h33);
        ind_wr(8'h01, 8'h10, 8'hEE);
        ind_wr(8'h00, 8'h00, 8'hEE);
        i_fixed_mode  = 1'b1;
        i_bar_cnt_sel = 2'h1;
        i_bar_size    = 16'h0004;
        i_line_size   = 16'h0009;
        ex = '{8'h11, 8'h22, 8'h33, 8'h11, 8'hDD, 8'hCC, 8'hEE,
               8'hDD, 8'hCC};
        run_frame;
        chk_line(1);
        chk_line(2);
    endtask
    task complete_run;
        if (err_total == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        #200000;
        err_total = err_total + 1;
        complete_run;
    end
    initial
    begin
        repeat (5) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        t_ref;
        t_bars;
        t_fixed;
        complete_run;
    end
endmodule // testbench
